// File: include/loop_dac_defines.vh
`ifndef LOOP_DAC_DEFINES_VH
`define LOOP_DAC_DEFINES_VH

// ------------------------------------------------------------
// register offsets (byte addresses, low eight address bits)
// ------------------------------------------------------------
`define LD_OFF_CTRL 8'h00
`define LD_OFF_STATUS 8'h04
`define LD_OFF_IRQ_STAT 8'h08
`define LD_OFF_IRQ_EN 8'h0c
`define LD_OFF_IRQ_CLR 8'h10
`define LD_OFF_DAC_WORD 8'h14
`define LD_OFF_SHIFT 8'h18

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define LD_CTRL_SWCLR 0
`define LD_CTRL_RXEN 1
`define LD_CTRL_RST 2'h2
// synchronisers wake high for link clock, data and load, low for the rest: no false edge, no range glitch
// order: link clock, data, load, clear, select 2, select 1
`define LD_PIN_IDLE 6'h38
`define LD_IRQ_UPD 0
`define LD_IRQ_FERR 1
`define LD_IRQ_CLR 2
`define LD_IRQ_W 3
`define LD_STAT_RANGE_LO 0
`define LD_STAT_HELD 2
`define LD_STAT_ASYNC 3
`define LD_STAT_BUSY 4
`define LD_STAT_CLRPIN 5

// ------------------------------------------------------------
// range codes, upper select is the high bit
// ------------------------------------------------------------
`define LD_RANGE_V5 2'h0
`define LD_RANGE_I4_20 2'h1
`define LD_RANGE_I0_20 2'h2
`define LD_RANGE_I0_24 2'h3

// ------------------------------------------------------------
// asynchronous frame timing, in link clock rising edges
// ------------------------------------------------------------
`define LD_WORD_BITS 16
`define LD_CELL_CLKS 9'h010
`define LD_START_CHECK 9'h008
`define LD_FIRST_DATA 9'h018
`define LD_CELL_MID 4'h8
`define LD_STOP_SAMPLE 9'h118
`define LD_ZERO_WORD 16'h0000

`endif

// File: rtl/loop_dac_serial_word_receiver.v
// Operation
// - clear high forces the output code to the bottom of span.
// - async frames are start 0, sixteen data bits, stop 1.
// - each async bit is sampled at its cell centre edge.
// - cells are 16 clocks; start cell begins after falling edge.
// - most significant bit sampled 24 clocks after start begins.
// - msb first, one bit every 16 clocks, second at 40.
// - a good stop bit moves the received word to the DAC.
// - bad stop gives a one link-clock high pulse on serial out.
// - a framing error discards the word, DAC keeps its value.
// - three-wire mode: load rising edge copies shift register to DAC.
// - clear keeps input data; output stays at minimum until update.
`include "loop_dac_defines.vh"

module loop_dac_serial_word_receiver (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire link_clk,
    input wire data_in,
    input wire load_strobe,
    input wire clear_in,
    input wire range_sel2,
    input wire range_sel1,
    output reg data_out,
    output reg [15:0] dac_code,
    output reg [1:0] range_code,
    output reg dac_update,
    output reg irq
);

// ------------------------------------------------------------
// pin synchronisers
// ------------------------------------------------------------
// bit order: link clock, data, load, clear, select 2, select 1
reg [5:0] pin_s1_r;
reg [5:0] pin_s2_r;
reg [5:0] pin_prev_r;
wire link_s;
wire data_s;
wire load_s;
wire clear_s;
wire link_rise;
wire load_rise;
wire clear_rise;

assign link_s = pin_s2_r[5];
assign data_s = pin_s2_r[4];
assign load_s = pin_s2_r[3];
assign clear_s = pin_s2_r[2];
assign link_rise = link_s && !pin_prev_r[5];
assign load_rise = load_s && !pin_prev_r[3];
assign clear_rise = clear_s && !pin_prev_r[2];

always @(posedge clk) begin
    if (srst) begin
        pin_s1_r <= `LD_PIN_IDLE;
        pin_s2_r <= `LD_PIN_IDLE;
        pin_prev_r <= `LD_PIN_IDLE;
    end else if (ce) begin
        pin_s1_r <= {link_clk, data_in, load_strobe, clear_in,
                     range_sel2, range_sel1};
        pin_s2_r <= pin_s1_r;
        pin_prev_r <= pin_s2_r;
    end
end

// ------------------------------------------------------------
// control registers
// ------------------------------------------------------------
reg [1:0] ctrl_r;
reg [`LD_IRQ_W-1:0] irq_stat_r;
reg [`LD_IRQ_W-1:0] irq_en_r;
reg [15:0] shift_r;
reg [15:0] dac_word_r;
reg held_r;
reg ferr_hold_r;

wire async_mode;
wire clr_active;
wire [15:0] rx_word;
wire rx_valid;
wire rx_ferr;
wire rx_busy;

// a permanently high load strobe means asynchronous mode
assign async_mode = load_s;
// pin and software clear act alike on the DAC output; only the pin raises the clear interrupt
assign clr_active = clear_s || ctrl_r[`LD_CTRL_SWCLR];

// ------------------------------------------------------------
// asynchronous receiver
// ------------------------------------------------------------
serial_word_rx u_rx (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .tick(link_rise),
    .enable(async_mode && ctrl_r[`LD_CTRL_RXEN]),
    .din(data_s),
    .word(rx_word),
    .word_valid(rx_valid),
    .frame_err(rx_ferr),
    .busy(rx_busy)
);

// ------------------------------------------------------------
// DAC register and clear
// ------------------------------------------------------------
reg update_nxt;
reg [15:0] dac_word_nxt;
reg held_nxt;

always @* begin
    update_nxt = 1'b0;
    dac_word_nxt = dac_word_r;
    // only a clean frame reaches the DAC
    if (async_mode && rx_valid) begin
        update_nxt = 1'b1;
        dac_word_nxt = rx_word;
    end
    // parallel load on rising strobe edge
    // the rising latch already reads as async mode, so test the edge alone
    if (load_rise) begin
        update_nxt = 1'b1;
        dac_word_nxt = shift_r;
    end
    // minimum stays until a fresh update after clear
    held_nxt = held_r;
    if (clr_active) begin
        held_nxt = 1'b1;
    end else if (update_nxt) begin
        held_nxt = 1'b0;
    end
end

always @(posedge clk) begin
    if (srst) begin
        shift_r <= 16'h0000;
        dac_word_r <= 16'h0000;
        held_r <= 1'b1;
        ferr_hold_r <= 1'b0;
        dac_code <= `LD_ZERO_WORD;
        range_code <= `LD_RANGE_V5;
        dac_update <= 1'b0;
        data_out <= 1'b0;
    end else if (ce) begin
        // three-wire shift register, msb leaves first
        if (!async_mode && link_rise) begin
            shift_r <= {shift_r[14:0], data_s};
        end
        dac_word_r <= dac_word_nxt;
        held_r <= held_nxt;
        // bottom of span is code zero in every range
        dac_code <= held_nxt ? `LD_ZERO_WORD : dac_word_nxt;
        dac_update <= update_nxt && !held_nxt;
        // upper select is the high bit
        range_code <= {pin_s2_r[1], pin_s2_r[0]};
        // high from stop sample until the next link edge
        if (rx_ferr) begin
            ferr_hold_r <= 1'b1;
        end else if (link_rise) begin
            ferr_hold_r <= 1'b0;
        end
        data_out <= async_mode ? (rx_ferr || (ferr_hold_r && !link_rise))
                               : shift_r[15];
    end
end

// ------------------------------------------------------------
// interrupts
// ------------------------------------------------------------
wire [`LD_IRQ_W-1:0] irq_event;
reg [`LD_IRQ_W-1:0] irq_clr_nxt;

assign irq_event = {clear_rise, async_mode && rx_ferr, update_nxt};

// ------------------------------------------------------------
// AHB-Lite slave
// ------------------------------------------------------------
reg dp_write_r;
reg [7:0] dp_addr_r;
wire ap_take;

assign ap_take = hsel && hready && htrans[1];

function [31:0] read_mux;
    input [7:0] a;
    begin
        case (a)
            `LD_OFF_CTRL: read_mux = {30'h0, ctrl_r};
            `LD_OFF_STATUS: read_mux = {26'h0, clear_s, rx_busy,
                                        async_mode, held_r, range_code};
            `LD_OFF_IRQ_STAT: read_mux = {29'h0, irq_stat_r};
            `LD_OFF_IRQ_EN: read_mux = {29'h0, irq_en_r};
            `LD_OFF_DAC_WORD: read_mux = {16'h0, dac_word_r};
            `LD_OFF_SHIFT: read_mux = {16'h0, shift_r};
            default: read_mux = 32'h0;
        endcase
    end
endfunction

always @* begin
    irq_clr_nxt = {`LD_IRQ_W{1'b0}};
    if (dp_write_r && dp_addr_r == `LD_OFF_IRQ_CLR) begin
        irq_clr_nxt = hwdata[`LD_IRQ_W-1:0];
    end
end

always @(posedge clk) begin
    if (srst) begin
        dp_write_r <= 1'b0;
        dp_addr_r <= 8'h00;
        hrdata <= 32'h0;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        ctrl_r <= `LD_CTRL_RST;
        irq_en_r <= {`LD_IRQ_W{1'b0}};
        irq_stat_r <= {`LD_IRQ_W{1'b0}};
        irq <= 1'b0;
    end else if (ce) begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        dp_write_r <= ap_take && hwrite;
        if (ap_take) begin
            dp_addr_r <= {haddr[7:2], 2'h0};
            if (!hwrite) begin
                hrdata <= read_mux({haddr[7:2], 2'h0});
            end
        end
        if (dp_write_r && dp_addr_r == `LD_OFF_CTRL) begin
            ctrl_r <= hwdata[1:0];
        end
        if (dp_write_r && dp_addr_r == `LD_OFF_IRQ_EN) begin
            irq_en_r <= hwdata[`LD_IRQ_W-1:0];
        end
        // a new event beats a clear in the same cycle
        irq_stat_r <= (irq_stat_r & ~irq_clr_nxt) | irq_event;
        irq <= |(((irq_stat_r & ~irq_clr_nxt) | irq_event) & irq_en_r);
    end
end

endmodule // loop_dac_serial_word_receiver

// File: rtl/serial_word_rx.v
`include "loop_dac_defines.vh"

module serial_word_rx (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire tick,
    input wire enable,
    input wire din,
    output reg [15:0] word,
    output reg word_valid,
    output reg frame_err,
    output wire busy
);

localparam ST_IDLE = 1'b0;
localparam ST_BUSY = 1'b1;

reg state_r;
reg [8:0] cnt_r;
reg [15:0] sh_r;
reg last_r;
wire [8:0] cnt_inc;
wire data_slot;

assign busy = state_r;
assign cnt_inc = cnt_r + 9'h001;
// data bits sit at 24, 40, ... 264: centre of each 16-clock cell
assign data_slot = (cnt_inc >= `LD_FIRST_DATA) &&
                   (cnt_inc < `LD_STOP_SAMPLE) &&
                   (cnt_inc[3:0] == `LD_CELL_MID);

always @(posedge clk) begin
    if (srst) begin
        state_r <= ST_IDLE;
        cnt_r <= 9'h000;
        sh_r <= 16'h0000;
        last_r <= 1'b1;
        word <= 16'h0000;
        word_valid <= 1'b0;
        frame_err <= 1'b0;
    end else if (ce) begin
        word_valid <= 1'b0;
        frame_err <= 1'b0;
        if (tick) begin
            last_r <= din;
            case (state_r)
                ST_IDLE: begin
                    // cell starts at first clock seeing the low level
                    if (enable && last_r && !din) begin
                        state_r <= ST_BUSY;
                        cnt_r <= 9'h000;
                    end
                end
                ST_BUSY: begin
                    cnt_r <= cnt_inc;
                    // a start that is high again at its centre is a glitch
                    if (cnt_inc == `LD_START_CHECK && din) begin
                        state_r <= ST_IDLE;
                    end
                    if (data_slot) begin
                        sh_r <= {sh_r[14:0], din};
                    end
                    if (cnt_inc == `LD_STOP_SAMPLE) begin
                        state_r <= ST_IDLE;
                        // good stop hands the word over
                        if (din) begin
                            word <= sh_r;
                            word_valid <= 1'b1;
                        end else begin
                            frame_err <= 1'b1;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
end

endmodule // serial_word_rx

// File: sim/host_serial_model.sv
module host_serial_model (
    output logic link_clk,
    output logic data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // frame sender, clock only within frames
    // ----------------------------------------
    initial begin
        link_clk = 1'b0;
        data_in = 1'b1;
    end
    // framing, idle high
    // trailing idle edges let the error pulse end
    task automatic send(input logic [15:0] w, input logic stp);
        int j;
        // keep link edges off the system clock edges
        #1;
        for (j = 0; j < 320; j++) begin
            data_in = (j < 16 || j >= 304) ? 1'b1 : (j < 32) ? 1'b0 :
                (j < 288) ? w[15 - (j - 32) / 16] : stp;
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
        end
    endtask
    // three-wire: one link clock per bit, msb first
    task automatic shift16(input logic [15:0] w);
        int j;
        #1;
        for (j = 0; j < 16; j++) begin
            data_in = w[15 - j];
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
        end
        data_in = 1'b1;
    endtask
endmodule // host_serial_model

// File: sim/loop_dac_serial_word_receiver_tb_top.sv
`include "loop_dac_defines.vh"
module loop_dac_serial_word_receiver_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, srst, hsel, hwrite, clear_in, range_sel2, range_sel1;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, s, r;
    logic hreadyout, hresp, link_clk, data_in, data_out, dac_update, irq;
    logic [15:0] dac_code, last;
    logic [1:0] range_code;
    logic dout_q, load_strobe;
    logic [16:0] e;
    logic [16:0] q[$];
    int miscompares, n_tests, i;
    loop_dac_serial_word_receiver loop_dac_serial_word_receiver_inst (
        .clk(clk), .srst(srst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .link_clk(link_clk), .data_in(data_in),
        .load_strobe(load_strobe), .clear_in(clear_in),
        .range_sel2(range_sel2),
        .range_sel1(range_sel1), .data_out(data_out), .dac_code(dac_code),
        .range_code(range_code), .dac_update(dac_update), .irq(irq));
    // latch held high except in the three-wire scenario
    host_serial_model host_serial_model_inst (.link_clk(link_clk),
        .data_in(data_in));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, exp);
        bus(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog, result monitor
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
    // error pulse must show the old code, update the new word
    always @(posedge clk) begin
        // serial out is the error pulse only while the latch is high
        if (dac_update === 1'b1 || (load_strobe === 1'b1 &&
                data_out === 1'b1 && dout_q !== 1'b1)) begin
            e = (q.size() > 0) ? q.pop_front() : 17'h1ffff;
            chk({15'h0, data_out, dac_code}, {15'h0, e});
        end
        dout_q <= data_out;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {hsel, hwrite, clear_in, range_sel2, range_sel1} = 5'h0;
        load_strobe = 1'b1;
        {htrans, haddr, hwdata} = 66'h0;
        srst = 1'b1;
        s = 32'h23c3;
        wait_clk(12);
        srst <= 1'b0;
        wait_clk(4);
        rd(`LD_OFF_CTRL, 32'h2);
        rd(`LD_OFF_STATUS, 32'hc);
        rd(32'h1c, 32'h0);
        bus(1'b1, `LD_OFF_IRQ_EN, 32'h3);
        for (i = 0; i < 3; i++) begin
            s = lfsr(s);
            last = s[15:0];
            q.push_back({1'b0, last});
            host_serial_model_inst.send(last, 1'b1);
            wait_clk(40);
        end
        rd(`LD_OFF_DAC_WORD, {16'h0, last});
        chk({31'h0, irq}, 32'h1);
        q.push_back({1'b1, last});
        host_serial_model_inst.send(~last, 1'b0);
        wait_clk(40);
        rd(`LD_OFF_DAC_WORD, {16'h0, last});
        rd(`LD_OFF_IRQ_STAT, 32'h3);
        bus(1'b1, `LD_OFF_IRQ_EN, 32'h0);
        wait_clk(3);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `LD_OFF_IRQ_EN, 32'h3);
        wait_clk(3);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `LD_OFF_IRQ_CLR, 32'h3);
        wait_clk(3);
        chk({31'h0, irq}, 32'h0);
        for (i = 0; i < 4; i++) begin
            {range_sel2, range_sel1} <= i[1:0];
            wait_clk(5);
            chk({30'h0, range_code}, i);
            rd(`LD_OFF_STATUS, 32'h8 | i);
        end
        clear_in <= 1'b1;
        wait_clk(5);
        chk({16'h0, dac_code}, 32'h0);
        clear_in <= 1'b0;
        wait_clk(5);
        chk({16'h0, dac_code}, 32'h0);
        rd(`LD_OFF_DAC_WORD, {16'h0, last});
        s = lfsr(s);
        last = s[15:0];
        q.push_back({1'b0, last});
        host_serial_model_inst.send(last, 1'b1);
        wait_clk(40);
        bus(1'b1, `LD_OFF_CTRL, 32'h0);
        host_serial_model_inst.send(~last, 1'b1);
        wait_clk(40);
        rd(`LD_OFF_DAC_WORD, {16'h0, last});
        // three-wire: shift a word in, then a rising latch loads it
        load_strobe <= 1'b0;
        s = lfsr(s);
        last = s[15:0];
        wait_clk(4);
        host_serial_model_inst.shift16(last);
        wait_clk(4);
        rd(`LD_OFF_SHIFT, {16'h0, last});
        q.push_back({1'b0, last});
        load_strobe <= 1'b1;
        wait_clk(6);
        rd(`LD_OFF_DAC_WORD, {16'h0, last});
        chk(q.size(), 32'h0);
        wrap_up();
    end
endmodule // loop_dac_serial_word_receiver_tb_top

// File: sim/loop_dac_sva.sv
module loop_dac_sva (
    input wire clk,
    input wire srst,
    input wire hreadyout,
    input wire hresp,
    input wire range_sel2,
    input wire range_sel1,
    input wire [1:0] range_code,
    input wire clear_in,
    input wire load_strobe,
    input wire data_out,
    input wire [15:0] dac_code,
    input wire dac_update,
    input wire irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // port checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ready_always_high_a: assert property (hreadyout == 1'b1)
        else $error("hreadyout low");
    resp_always_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    range_follows_pins_a: assert property (
        $stable({range_sel2, range_sel1})[*6]
        |-> range_code == {range_sel2, range_sel1})
        else $error("range code wrong");
    clear_forces_zero_a: assert property (
        clear_in[*4] |-> dac_code == 16'h0000)
        else $error("code not zero in clear");
    code_needs_update_a: assert property (
        dac_code != $past(dac_code) && dac_code != 16'h0000 |-> dac_update)
        else $error("code moved without update");
    update_single_pulse_a: assert property (
        dac_update |=> !dac_update)
        else $error("update pulse too long");
    error_pulse_width_a: assert property (
        load_strobe && $rose(data_out) |-> data_out[*8] ##[1:12] !data_out)
        else $error("error pulse width wrong");
    error_blocks_update_a: assert property (
        load_strobe && $rose(data_out) |-> !dac_update[*8])
        else $error("update on framing error");
    cover property (dac_update);
    cover property ($rose(data_out));
    cover property ($rose(irq));
    cover property (clear_in[*4]);
endmodule // loop_dac_sva

bind loop_dac_serial_word_receiver loop_dac_sva loop_dac_sva_inst (
    .clk(clk), .srst(srst), .hreadyout(hreadyout), .hresp(hresp),
    .range_sel2(range_sel2), .range_sel1(range_sel1),
    .range_code(range_code), .clear_in(clear_in),
    .load_strobe(load_strobe), .data_out(data_out), .dac_code(dac_code),
    .dac_update(dac_update), .irq(irq));
